// ===== rtl/frt_pkg.sv
// package: constants, register map and types of the flow rate totalizer
package frt_pkg;
	// ==========================================================
	// timing
	localparam int unsigned CLK_HZ         = 20_000_000;
	localparam int unsigned RATE_TIMEOUT_S = 10;
	localparam int unsigned GATE_S         = 1;
	// ==========================================================
	// fixed point: scale factors Q12.20, flow values Q16.16, totals Q44.20
	localparam int unsigned K_FRAC   = 20;
	localparam int unsigned V_FRAC   = 16;
	localparam logic [31:0] K_MIN    = 32'h0000000a;
	localparam logic [31:0] K_ONE    = 32'h00100000;
	localparam logic [31:0] DIV_MIN  = 32'h00000002;
	localparam logic [15:0] CODE_MAX = 16'hffff;
	localparam int unsigned LOOP_W   = 16;
	localparam int unsigned LIN_PTS  = 30;
	localparam logic [5:0]  DIV_LAST = 6'h3f;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_UNIT_LO = 8'h04;
	localparam logic [7:0] OFF_UNIT_HI = 8'h08;
	localparam logic [7:0] OFF_RATE_K  = 8'h0c;
	localparam logic [7:0] OFF_TOTAL_K = 8'h10;
	localparam logic [7:0] OFF_RNG_LO  = 8'h14;
	localparam logic [7:0] OFF_RNG_HI  = 8'h18;
	localparam logic [7:0] OFF_RET_LO  = 8'h1c;
	localparam logic [7:0] OFF_RET_HI  = 8'h20;
	localparam logic [7:0] OFF_VSTEP   = 8'h24;
	localparam logic [7:0] OFF_PWIDTH  = 8'h28;
	localparam logic [7:0] OFF_FDIV    = 8'h2c;
	localparam logic [7:0] OFF_LCOUNT  = 8'h30;
	localparam logic [7:0] OFF_LINDEX  = 8'h34;
	localparam logic [7:0] OFF_LIN_IN  = 8'h38;
	localparam logic [7:0] OFF_LIN_OUT = 8'h3c;
	localparam logic [7:0] OFF_RATE    = 8'h40;
	localparam logic [7:0] OFF_TOT_LO  = 8'h44;
	localparam logic [7:0] OFF_TOT_HI  = 8'h48;
	localparam logic [7:0] OFF_AUX     = 8'h4c;
	localparam logic [7:0] OFF_STATUS  = 8'h50;
	// ==========================================================
	// control bits
	localparam int unsigned CTRL_LOOP = 0;
	localparam int unsigned CTRL_FREQ = 1;
	localparam int unsigned CTRL_LIN  = 2;
	localparam int unsigned CTRL_TRST = 3;
	// ==========================================================
	// time base characters and their seconds
	localparam logic [7:0]  TB_SEC   = 8'h73;
	localparam logic [7:0]  TB_MIN   = 8'h6d;
	localparam logic [7:0]  TB_HOUR  = 8'h68;
	localparam logic [7:0]  TB_DAY   = 8'h64;
	localparam logic [16:0] MUL_SEC  = 17'h00001;
	localparam logic [16:0] MUL_MIN  = 17'h0003c;
	localparam logic [16:0] MUL_HOUR = 17'h00e10;
	localparam logic [16:0] MUL_DAY  = 17'h15180;
	// ==========================================================
	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_SEARCH = 3'b001,
		S_LDIV   = 3'b010,
		S_RSET   = 3'b011,
		S_RDIV   = 3'b100
	} frt_state_t;
endpackage

// ===== rtl/frt_top.sv
// flow rate totalizer with 4-20 mA and pulse retransmission, APB slave
module frt_top #(
	parameter int unsigned NUM_ALARMS       = 2,
	parameter int unsigned RATE_TIMEOUT_CYC = frt_pkg::CLK_HZ * frt_pkg::RATE_TIMEOUT_S,
	parameter int unsigned GATE_CYC         = frt_pkg::CLK_HZ * frt_pkg::GATE_S
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          flow_pulse,
	input  wire logic [frt_pkg::LOOP_W-1:0]    loop_code,
	input  wire logic                          batch_end,
	input  wire logic [NUM_ALARMS-1:0]         alarm_active,
	input  wire logic [NUM_ALARMS-1:0]         alarm_drive,
	output logic      [NUM_ALARMS-1:0]         alarm_relay,
	output logic      [NUM_ALARMS-1:0]         alarm_led,
	output logic      [15:0]                   retransmit_code,
	output logic                               pulse_out
);
	// ==========================================================
	// configuration registers
	logic [2:0]         ctrl;
	logic [31:0]        unit_lo;
	logic [15:0]        unit_hi;
	logic [31:0]        rate_scale_factor;
	logic [31:0]        total_k;
	logic signed [31:0] range_low_limit;
	logic signed [31:0] range_high_limit;
	logic signed [31:0] retransmit_low_value;
	logic signed [31:0] retransmit_high_value;
	logic [31:0]        vol_step;
	logic [31:0]        pulse_width;
	logic [31:0]        freq_div;
	logic [4:0]         lin_count;
	logic [4:0]         lin_index;
	logic signed [31:0] lin_in  [frt_pkg::LIN_PTS];
	logic signed [31:0] lin_out [frt_pkg::LIN_PTS];
	logic               tot_clr;
	// ==========================================================
	// measurement state
	frt_pkg::frt_state_t st;
	localparam frt_pkg::frt_state_t S_IDLE = frt_pkg::S_IDLE, S_SEARCH = frt_pkg::S_SEARCH,
		S_LDIV = frt_pkg::S_LDIV, S_RSET = frt_pkg::S_RSET, S_RDIV = frt_pkg::S_RDIV;
	logic signed [31:0] rate_val;
	logic signed [31:0] aux_value;
	logic signed [31:0] x;
	logic [63:0]        total;
	logic [63:0]        vol_acc;
	logic               pulse_q;
	logic [15:0]        pulse_cnt;
	logic [15:0]        gate_pulses;
	logic [31:0]        gate_ctr;
	logic [31:0]        idle_ctr;
	logic               timed_out;
	logic [31:0]        pw_ctr;
	logic [31:0]        fcnt;
	logic [4:0]         idx;
	logic               neg;
	logic [63:0]        dq;
	logic [32:0]        drem;
	logic [31:0]        dden;
	logic [5:0]         dcnt;
	// ==========================================================
	// register access decode
	wire acc      = psel & penable;
	wire wr_en    = acc & pready & pwrite;
	wire addr_ok  = paddr <= frt_pkg::OFF_STATUS && paddr[1:0] == 2'b00;
	wire loop_sel = ctrl[frt_pkg::CTRL_LOOP];
	wire freq_sel = ctrl[frt_pkg::CTRL_FREQ] & ~loop_sel;
	wire lin_on   = ctrl[frt_pkg::CTRL_LIN] & loop_sel & (lin_count >= 5'd2);
	wire [31:0] eff_rk  = (rate_scale_factor == 32'h0) ? frt_pkg::K_MIN : rate_scale_factor;
	wire [31:0] eff_tk  = (total_k == 32'h0) ? frt_pkg::K_MIN : total_k;
	wire [31:0] eff_div = (freq_div < frt_pkg::DIV_MIN) ? frt_pkg::DIV_MIN : freq_div;
	wire [7:0]  tb_char = unit_hi[15:8];
	// rightmost unit character selects the rate time base
	wire [16:0] tb_mult = (tb_char == frt_pkg::TB_MIN)  ? frt_pkg::MUL_MIN :
	                      (tb_char == frt_pkg::TB_HOUR) ? frt_pkg::MUL_HOUR :
	                      (tb_char == frt_pkg::TB_DAY)  ? frt_pkg::MUL_DAY : frt_pkg::MUL_SEC;
	wire [31:0] rd_data =
		(paddr == frt_pkg::OFF_CTRL)    ? {29'h0, ctrl} :
		(paddr == frt_pkg::OFF_UNIT_LO) ? unit_lo :
		(paddr == frt_pkg::OFF_UNIT_HI) ? {16'h0, unit_hi} :
		(paddr == frt_pkg::OFF_RATE_K)  ? rate_scale_factor :
		(paddr == frt_pkg::OFF_TOTAL_K) ? total_k :
		(paddr == frt_pkg::OFF_RNG_LO)  ? range_low_limit :
		(paddr == frt_pkg::OFF_RNG_HI)  ? range_high_limit :
		(paddr == frt_pkg::OFF_RET_LO)  ? retransmit_low_value :
		(paddr == frt_pkg::OFF_RET_HI)  ? retransmit_high_value :
		(paddr == frt_pkg::OFF_VSTEP)   ? vol_step :
		(paddr == frt_pkg::OFF_PWIDTH)  ? pulse_width :
		(paddr == frt_pkg::OFF_FDIV)    ? freq_div :
		(paddr == frt_pkg::OFF_LCOUNT)  ? {27'h0, lin_count} :
		(paddr == frt_pkg::OFF_LINDEX)  ? {27'h0, lin_index} :
		(paddr == frt_pkg::OFF_LIN_IN)  ? lin_in[lin_index] :
		(paddr == frt_pkg::OFF_LIN_OUT) ? lin_out[lin_index] :
		(paddr == frt_pkg::OFF_RATE)    ? rate_val :
		(paddr == frt_pkg::OFF_TOT_LO)  ? total[31:0] :
		(paddr == frt_pkg::OFF_TOT_HI)  ? total[63:32] :
		(paddr == frt_pkg::OFF_AUX)     ? aux_value :
		(paddr == frt_pkg::OFF_STATUS)  ? {30'h0, st != S_IDLE, timed_out} : 32'h0;
	// ==========================================================
	// APB slave: one wait state, so read data leaves a flip-flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end
		else
		begin
			pready  <= acc & ~pready;
			pslverr <= acc & ~pready & ~addr_ok;
			if (acc & ~pready)
				prdata <= (addr_ok & ~pwrite) ? rd_data : 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl                  <= 3'h0;
			unit_lo               <= 32'h0;
			unit_hi               <= {frt_pkg::TB_SEC, 8'h0};
			rate_scale_factor     <= frt_pkg::K_ONE;
			total_k               <= frt_pkg::K_ONE;
			range_low_limit       <= 32'h0;
			range_high_limit      <= 32'h0;
			retransmit_low_value  <= 32'h0;
			retransmit_high_value <= 32'h0;
			vol_step              <= 32'h0;
			pulse_width           <= 32'h0;
			freq_div              <= frt_pkg::DIV_MIN;
			lin_count             <= 5'h0;
			lin_index             <= 5'h0;
			tot_clr               <= 1'b0;
		end
		else
		begin
			tot_clr <= wr_en && paddr == frt_pkg::OFF_CTRL && pwdata[frt_pkg::CTRL_TRST];
			if (wr_en)
			begin
				case (paddr)
					frt_pkg::OFF_CTRL:    ctrl <= pwdata[2:0];
					frt_pkg::OFF_UNIT_LO: unit_lo <= pwdata;
					frt_pkg::OFF_UNIT_HI: unit_hi <= pwdata[15:0];
					frt_pkg::OFF_RATE_K:  rate_scale_factor <= pwdata;
					frt_pkg::OFF_TOTAL_K: total_k <= pwdata;
					frt_pkg::OFF_RNG_LO:  range_low_limit <= pwdata;
					frt_pkg::OFF_RNG_HI:  range_high_limit <= pwdata;
					frt_pkg::OFF_RET_LO:  retransmit_low_value <= pwdata;
					frt_pkg::OFF_RET_HI:  retransmit_high_value <= pwdata;
					frt_pkg::OFF_VSTEP:   vol_step <= pwdata;
					frt_pkg::OFF_PWIDTH:  pulse_width <= pwdata;
					frt_pkg::OFF_FDIV:    freq_div <= pwdata;
					frt_pkg::OFF_LCOUNT:  lin_count <= (pwdata > 32'd30) ? 5'd30 : pwdata[4:0];
					frt_pkg::OFF_LINDEX:  lin_index <= (pwdata > 32'd29) ? 5'd29 : pwdata[4:0];
					default: ;
				endcase
			end
		end
	end

	// table has no reset: software loads it before enabling it
	always_ff @(posedge pclk)
	begin
		if (wr_en && paddr == frt_pkg::OFF_LIN_IN)
			lin_in[lin_index] <= pwdata;
		if (wr_en && paddr == frt_pkg::OFF_LIN_OUT)
			lin_out[lin_index] <= pwdata;
	end
	// ==========================================================
	// input scaling and pulse counting
	wire signed [63:0] span   = 64'(range_high_limit) - 64'(range_low_limit);
	wire signed [63:0] sc_mul = span * $signed({48'h0, loop_code});
	wire signed [31:0] scaled = range_low_limit + 32'(sc_mul >>> frt_pkg::LOOP_W);
	wire               rise   = flow_pulse & ~pulse_q;
	wire               gate_t = gate_ctr == 32'(GATE_CYC - 1);
	wire [63:0] prate_w = 64'(gate_pulses) * 64'(eff_rk) * 64'(tb_mult);
	wire signed [31:0] prate = 32'(prate_w >> (frt_pkg::K_FRAC - frt_pkg::V_FRAC));
	// loop mode adds one second worth of rate per gate, whatever the time base label
	wire [63:0] loop_inc = rate_val[31] ? 64'h0 :
		(64'(rate_val) * 64'(eff_tk)) >> frt_pkg::V_FRAC;
	wire [63:0] tot_inc = loop_sel ? (gate_t ? loop_inc : 64'h0) :
		(rise ? 64'(eff_tk) : 64'h0);
	wire        vol_clr  = tot_clr | batch_end;
	wire [63:0] vol_sum  = (vol_clr ? 64'h0 : vol_acc) + tot_inc;
	wire        vol_fire = vol_step != 32'h0 && vol_sum >= 64'(vol_step);
	wire [31:0] next_pw  = vol_fire ? pulse_width : (pw_ctr != 32'h0 ? pw_ctr - 32'h1 : 32'h0);
	wire [31:0] next_fc  = rise ? ((fcnt >= eff_div - 32'h1) ? 32'h0 : fcnt + 32'h1) : fcnt;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pulse_q     <= 1'b0;
			pulse_cnt   <= 16'h0;
			gate_pulses <= 16'h0;
			gate_ctr    <= 32'h0;
			idle_ctr    <= 32'h0;
			timed_out   <= 1'b1;
			total       <= 64'h0;
			vol_acc     <= 64'h0;
			pw_ctr      <= 32'h0;
			fcnt        <= 32'h0;
			pulse_out   <= 1'b0;
			aux_value   <= 32'h0;
			alarm_relay <= '0;
			alarm_led   <= '0;
		end
		else
		begin
			pulse_q  <= flow_pulse;
			gate_ctr <= gate_t ? 32'h0 : gate_ctr + 32'h1;
			if (gate_t)
			begin
				gate_pulses <= pulse_cnt + {15'h0, rise};
				pulse_cnt   <= 16'h0;
			end
			else if (rise)
				pulse_cnt <= pulse_cnt + 16'h1;
			idle_ctr  <= rise ? 32'h0 : (timed_out ? idle_ctr : idle_ctr + 32'h1);
			timed_out <= ~rise & (timed_out | idle_ctr >= 32'(RATE_TIMEOUT_CYC - 1));
			// a pulse in the clearing cycle still counts
			total     <= (tot_clr ? 64'h0 : total) + tot_inc;
			vol_acc   <= vol_fire ? vol_sum - 64'(vol_step) : vol_sum;
			pw_ctr    <= next_pw;
			fcnt      <= next_fc;
			pulse_out <= freq_sel ? (next_fc < (eff_div >> 1)) : (next_pw != 32'h0);
			aux_value <= loop_sel ? 32'h0 : scaled;
			alarm_led   <= alarm_active;
			alarm_relay <= alarm_drive;
		end
	end
	// ==========================================================
	// linearization search, interpolation and retransmission divider
	wire [4:0]         nxt    = (idx == 5'(frt_pkg::LIN_PTS - 1)) ? idx : idx + 5'h1;
	wire               l_stop = (nxt >= lin_count) || (nxt == idx) || (lin_in[nxt] < lin_in[idx]);
	wire signed [31:0] dy     = lin_out[nxt] - lin_out[idx];
	wire [31:0]        dy_mag = dy[31] ? 32'(-dy) : 32'(dy);
	wire [31:0]        dx_in  = 32'(x - lin_in[idx]);
	wire signed [31:0] r_diff = rate_val - retransmit_low_value;
	wire signed [31:0] r_span = retransmit_high_value - retransmit_low_value;
	wire [32:0]        rem_sh = {drem[31:0], dq[63]};
	wire               rem_ge = rem_sh >= {1'b0, dden};
	wire [63:0]        q_nx   = {dq[62:0], rem_ge};
	wire [31:0]        q_lin  = (dden == 32'h0) ? 32'h0 : q_nx[31:0];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st              <= S_IDLE;
			x               <= 32'h0;
			idx             <= 5'h0;
			neg             <= 1'b0;
			rate_val        <= 32'h0;
			dq              <= 64'h0;
			drem            <= 33'h0;
			dden            <= 32'h0;
			dcnt            <= 6'h0;
			retransmit_code <= 16'h0;
		end
		else
		begin
			case (st)
				S_IDLE:
				begin
					x   <= scaled;
					idx <= 5'h0;
					if (lin_on)
						st <= S_SEARCH;
					else
					begin
						rate_val <= loop_sel ? scaled : (timed_out ? 32'h0 : prate);
						st       <= S_RSET;
					end
				end
				S_SEARCH:
				begin
					if (idx == 5'h0 && x < lin_in[0])
					begin
						rate_val <= lin_out[0];
						st       <= S_RSET;
					end
					else if (l_stop)
					begin
						rate_val <= lin_out[idx];
						st       <= S_RSET;
					end
					else if (x > lin_in[nxt])
						idx <= nxt;
					else
					begin
						dq   <= 64'(dx_in) * 64'(dy_mag);
						drem <= 33'h0;
						dden <= 32'(lin_in[nxt] - lin_in[idx]);
						neg  <= dy[31];
						dcnt <= 6'h0;
						st   <= S_LDIV;
					end
				end
				S_LDIV:
				begin
					dq   <= q_nx;
					drem <= rem_ge ? rem_sh - {1'b0, dden} : rem_sh;
					dcnt <= dcnt + 6'h1;
					if (dcnt == frt_pkg::DIV_LAST)
					begin
						rate_val <= lin_out[idx] + (neg ? -$signed(q_lin) : $signed(q_lin));
						st       <= S_RSET;
					end
				end
				S_RSET:
				begin
					if (r_diff <= 0 || r_span <= 0)
					begin
						retransmit_code <= 16'h0;
						st              <= S_IDLE;
					end
					else
					begin
						dq   <= {16'h0, r_diff, 16'h0};
						drem <= 33'h0;
						dden <= r_span;
						dcnt <= 6'h0;
						st   <= S_RDIV;
					end
				end
				S_RDIV:
				begin
					dq   <= q_nx;
					drem <= rem_ge ? rem_sh - {1'b0, dden} : rem_sh;
					dcnt <= dcnt + 6'h1;
					if (dcnt == frt_pkg::DIV_LAST)
					begin
						retransmit_code <= (q_nx > 64'(frt_pkg::CODE_MAX)) ?
							frt_pkg::CODE_MAX : q_nx[15:0];
						st <= S_IDLE;
					end
				end
				default: st <= S_IDLE;
			endcase
		end
	end
	// ==========================================================
	// assertions
	a_zero_rate_factor: assert property (@(posedge pclk) disable iff (!presetn)
		rate_scale_factor == 32'h0 |-> eff_rk == frt_pkg::K_MIN)
		else $error("zero rate factor not substituted");
	a_pulse_totals: assert property (@(posedge pclk) disable iff (!presetn)
		(rise && !loop_sel && !tot_clr) |=> total == $past(total) + 64'($past(eff_tk)))
		else $error("pulse not added to total");
	a_timeout_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(st == S_IDLE && !loop_sel && timed_out && !lin_on) |=> rate_val == 32'h0)
		else $error("rate shown after timeout");
	a_pulse_revives: assert property (@(posedge pclk) disable iff (!presetn)
		rise |=> !timed_out ##0 idle_ctr == 32'h0)
		else $error("pulse did not restart rate window");
	a_freq_pulse_only: assert property (@(posedge pclk) disable iff (!presetn)
		(loop_sel && ctrl[frt_pkg::CTRL_FREQ]) |=> pulse_out == ($past(next_pw) != 32'h0))
		else $error("frequency mode with loop input");
	a_vol_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(batch_end && tot_inc == 64'h0) |=> vol_acc == 64'h0)
		else $error("step accumulator not cleared");
	a_lin_below: assert property (@(posedge pclk) disable iff (!presetn)
		(st == S_SEARCH && idx == 5'h0 && x < lin_in[0]) |=> rate_val == $past(lin_out[0]))
		else $error("below table not first output");
	a_lin_stop: assert property (@(posedge pclk) disable iff (!presetn)
		(st == S_SEARCH && !(idx == 5'h0 && x < lin_in[0]) && l_stop)
		|=> st == S_RSET && rate_val == $past(lin_out[idx]))
		else $error("search did not stop at table end");
	a_div_min: assert property (@(posedge pclk) disable iff (!presetn)
		(freq_sel && rise && fcnt == eff_div - 32'h1) |=> fcnt == 32'h0 ##0 pulse_out)
		else $error("frequency divider wrap wrong");
	a_ret_floor: assert property (@(posedge pclk) disable iff (!presetn)
		(st == S_RSET && r_diff <= 0) |=> retransmit_code == 16'h0 && st == S_IDLE)
		else $error("retransmit below low value not 4 mA");
endmodule

// ===== verification/frt_flow_src.sv
// flow sensor model: pulse train and loop current reading
module frt_flow_src
(
	input  wire logic        pclk,
	output logic             flow_pulse,
	output logic [15:0]      loop_code
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		flow_pulse = 1'b0;
		loop_code  = 16'h0000;
	end
	// ==========================================================
	// one cycle high, then at least one low cycle before the next pulse
	task automatic pulses(input int n, input int gap);
		repeat (n)
		begin
			@(posedge pclk) flow_pulse <= 1'b1;
			@(posedge pclk) flow_pulse <= 1'b0;
			repeat (gap) @(posedge pclk);
		end
	endtask
	task automatic set_loop(input logic [15:0] c);
		@(posedge pclk) loop_code <= c;
	endtask
endmodule

// ===== verification/tb.sv
// self-checking bench of the flow rate totalizer
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned TO = 200;
	typedef struct {logic err; logic [31:0] mask; logic [31:0] data;} frt_exp_t;
	logic        pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr;
	logic        batch_end, flow_pulse, pulse_out, pout_q;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, k;
	logic [15:0] loop_code, retransmit_code;
	logic [1:0]  alarm_active, alarm_drive, alarm_relay, alarm_led;
	int          fail_count, n_tests, n_rise, n_high;
	frt_exp_t    q[$];
	// table points in Q16.16; the fourth input point is smaller and must end the search
	logic [31:0] lin_x [4] = '{32'h000a0000, 32'h00280000, 32'h005a0000, 32'h00050000};
	logic [31:0] lin_y [4] = '{32'h00640000, 32'h012c0000, 32'h03200000, 32'h03e70000};
	frt_top #(.NUM_ALARMS(2), .RATE_TIMEOUT_CYC(TO), .GATE_CYC(20)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .flow_pulse(flow_pulse),
		.loop_code(loop_code), .batch_end(batch_end), .alarm_active(alarm_active),
		.alarm_drive(alarm_drive), .alarm_relay(alarm_relay), .alarm_led(alarm_led),
		.retransmit_code(retransmit_code), .pulse_out(pulse_out));
	frt_flow_src src (.pclk(pclk), .flow_pulse(flow_pulse), .loop_code(loop_code));
	always #25 pclk = ~pclk;
	// ==========================================================
	// reporting
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic fail(input string m);
		$display("ERROR t=%0t %s", $time, m);
		fail_count++;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
			fail("level or count mismatch");
	endtask
	task automatic cmp_rd(input frt_exp_t e);
		n_tests++;
		if (pslverr !== e.err || (prdata & e.mask) !== (e.data & e.mask))
			fail("apb answer mismatch");
	endtask
	// ==========================================================
	// apb master: request held until pready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input frt_exp_t e);
		int n;
		q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			fail("apb timeout");
			print_verdict();
		end
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, '{1'b0, 32'h0, 32'h0});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		xfer(1'b0, a, 32'h0, '{1'b0, m, d});
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	// ==========================================================
	// monitor: oldest note is compared when an answer appears
	always @(posedge pclk)
	begin
		pout_q <= pulse_out;
		if (pulse_out === 1'b1 && pout_q !== 1'b1)
			n_rise++;
		if (pulse_out === 1'b1)
			n_high++;
		if (psel && penable && pready === 1'b1)
		begin
			if (q.size() == 0)
				fail("unexpected answer");
			else
				cmp_rd(q.pop_front());
		end
	end
	// ==========================================================
	initial
	begin
		{presetn, psel, penable, pwrite, batch_end, paddr, pwdata} = '0;
		{alarm_active, alarm_drive} = '0;
		k = $urandom(32'h95d78608);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(frt_pkg::OFF_CTRL, 0, '1);
		rd(frt_pkg::OFF_RATE_K, frt_pkg::K_ONE, '1);
		rd(frt_pkg::OFF_FDIV, 2, '1);
		rd(frt_pkg::OFF_UNIT_HI, 32'h7300, '1);
		xfer(1'b0, 8'h54, 0, '{1'b1, '1, 32'h0});
		xfer(1'b1, 8'h02, 0, '{1'b1, '1, 32'h0});
		wr(frt_pkg::OFF_TOT_LO, '1);
		rd(frt_pkg::OFF_TOT_LO, 0, '1);
		done("register map");
		k = $urandom_range(32'h000fffff, 1);
		wr(frt_pkg::OFF_TOTAL_K, k);
		wr(frt_pkg::OFF_CTRL, 32'h8);
		src.pulses(5, $urandom_range(12, 8));
		rd(frt_pkg::OFF_TOT_LO, 5 * k, '1);
		wr(frt_pkg::OFF_TOTAL_K, 0);
		wr(frt_pkg::OFF_CTRL, 32'h8);
		src.pulses(4, $urandom_range(12, 8));
		rd(frt_pkg::OFF_TOT_LO, 4 * frt_pkg::K_MIN, '1);
		rd(frt_pkg::OFF_STATUS, 0, 1);
		repeat (TO + 20) @(posedge pclk);
		rd(frt_pkg::OFF_STATUS, 1, 1);
		rd(frt_pkg::OFF_RATE, 0, '1);
		src.pulses(1, 2);
		rd(frt_pkg::OFF_STATUS, 0, 1);
		rd(frt_pkg::OFF_TOT_LO, 5 * frt_pkg::K_MIN, '1);
		done("totals and timeout");
		k = $urandom_range(32'h000fffff, 32'h00010000);
		wr(frt_pkg::OFF_RATE_K, k);
		wr(frt_pkg::OFF_UNIT_HI, 32'h6d00);
		// a ten-cycle pulse period puts exactly two pulses in every 20-cycle gate
		fork
			src.pulses(10, 8);
			begin
				repeat (60) @(posedge pclk);
				rd(frt_pkg::OFF_RATE, (32'd2 * k * 32'(frt_pkg::MUL_MIN))
					>> (frt_pkg::K_FRAC - frt_pkg::V_FRAC), '1);
			end
		join
		done("pulse rate");
		wr(frt_pkg::OFF_TOTAL_K, frt_pkg::K_ONE);
		wr(frt_pkg::OFF_VSTEP, 32'h00300000);
		wr(frt_pkg::OFF_PWIDTH, 5);
		wr(frt_pkg::OFF_CTRL, 32'h8);
		{n_rise, n_high} = '0;
		src.pulses(9, 10);
		chk(32'(n_rise), 3);
		chk(32'(n_high), 15);
		n_rise = 0;
		src.pulses(2, 10);
		@(posedge pclk) batch_end <= 1'b1;
		@(posedge pclk) batch_end <= 1'b0;
		src.pulses(2, 10);
		chk(32'(n_rise), 0);
		src.pulses(1, 10);
		chk(32'(n_rise), 1);
		done("volumetric");
		wr(frt_pkg::OFF_FDIV, 4);
		wr(frt_pkg::OFF_CTRL, 32'h2);
		// the mode switch itself may raise the output; let it settle before counting
		repeat (2) @(posedge pclk);
		n_rise = 0;
		src.pulses(12, 3);
		chk(32'(n_rise), 3);
		wr(frt_pkg::OFF_FDIV, 1);
		n_rise = 0;
		src.pulses(12, 3);
		chk(32'(n_rise), 6);
		done("frequency");
		wr(frt_pkg::OFF_RNG_HI, 32'h00640000);
		wr(frt_pkg::OFF_RET_HI, 32'h00640000);
		src.set_loop(16'h8000);
		wr(frt_pkg::OFF_CTRL, 0);
		// one pipeline pass takes at most about 170 cycles
		repeat (400) @(posedge pclk);
		rd(frt_pkg::OFF_AUX, 32'h00320000, '1);
		wr(frt_pkg::OFF_CTRL, 32'h3);
		wr(frt_pkg::OFF_RATE_K, $urandom_range(32'h00fffff, 32'h0020000));
		wr(frt_pkg::OFF_UNIT_HI, 32'h6800);
		repeat (400) @(posedge pclk);
		rd(frt_pkg::OFF_RATE, 32'h00320000, '1);
		rd(frt_pkg::OFF_AUX, 0, '1);
		chk(32'(retransmit_code), 32'h8000);
		done("loop input");
		foreach (lin_x[i])
		begin
			wr(frt_pkg::OFF_LINDEX, i);
			wr(frt_pkg::OFF_LIN_IN, lin_x[i]);
			wr(frt_pkg::OFF_LIN_OUT, lin_y[i]);
		end
		wr(frt_pkg::OFF_LCOUNT, 4);
		wr(frt_pkg::OFF_CTRL, 32'h5);
		repeat (400) @(posedge pclk);
		// 50 lies between 40 and 90: 300 + 10 * 500 / 50 = 400
		rd(frt_pkg::OFF_RATE, 32'h01900000, '1);
		src.set_loop(16'h0000);
		repeat (400) @(posedge pclk);
		rd(frt_pkg::OFF_RATE, lin_y[0], '1);
		src.set_loop(16'hf000);
		repeat (400) @(posedge pclk);
		rd(frt_pkg::OFF_RATE, lin_y[2], '1);
		done("linearization");
		repeat (3)
		begin
			k = $urandom;
			alarm_active <= k[1:0];
			alarm_drive <= k[3:2];
			repeat (2) @(posedge pclk);
			chk(32'(alarm_led), 32'(k[1:0]));
			chk(32'(alarm_relay), 32'(k[3:2]));
		end
		done("alarms");
		print_verdict();
	end
endmodule
